//--- rtl/sfr_pkg.sv
// Purpose : Shared constants of the serial flash status/read front end
// Assumes : Single-bit serial link, mode 0 or mode 3
// Notes   : Frame counts are rising-edge counts since chip select fell
package sfr_pkg;
   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_LOW_PWR_READ = 8'h03;
   localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
   localparam logic [7:0] CMD_WRITE_EN     = 8'h06;
   localparam logic [7:0] CMD_FAST_READ    = 8'h0B;

   // ****************************************
   // Status register layout
   // ****************************************
   localparam int         SR_BUSY   = 0;
   localparam int         SR_WEL    = 1;
   localparam int         SR_LOCK   = 7;
   localparam logic [7:0] SR_NV_MASK = 8'hBC;
   localparam logic [7:0] SR_RESET   = 8'h00;

   // ****************************************
   // Frame counts
   // ****************************************
   localparam logic [5:0] CNT_CMD_END   = 6'h07;
   localparam logic [5:0] CNT_DATA_END  = 6'h0F;
   localparam logic [5:0] CNT_ADDR_LO   = 6'h08;
   localparam logic [5:0] CNT_ADDR_HI   = 6'h1F;
   localparam logic [5:0] START_STATUS  = 6'h08;
   localparam logic [5:0] START_LP_READ = 6'h20;
   localparam logic [5:0] START_FAST    = 6'h28;
   localparam logic [5:0] LEN_CMD_ONLY  = 6'h08;
   localparam logic [5:0] LEN_STATUS_WR = 6'h10;
   localparam logic [5:0] CNT_MAX       = 6'h3F;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam int         ADDR_W        = 21;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS   = 25;
   localparam int SR_WRITE_NS     = 10000;
   localparam int SR_WRITE_CYCLES = (SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOST_HALF_SCK   = 2;
   localparam int HOST_GAP_CYCLES = 4;

   // Array contents are outside this block: reads return an address pattern
   function automatic logic [7:0] sfr_fill_byte(input logic [ADDR_W-1:0] addr);
      sfr_fill_byte = addr[7:0] ^ addr[15:8] ^ {3'h0, addr[20:16]};
   endfunction
endpackage

//--- rtl/sfr_link_if.sv
// Purpose : Serial link between host controller and flash front end
// Assumes : Output line is pulled high when nobody drives it
// Notes   : so_line is the resolved wire level
interface sfr_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic wp_n;
   logic so_line;

   assign so_line = so_oe ? so : 1'b1;

   modport device (input cs_n, input sck, input si, input wp_n, output so, output so_oe);
   modport host   (output cs_n, output sck, output si, output wp_n, input so_line);
endinterface

//--- rtl/sfr_sync.sv
// Purpose : Two-flop synchroniser
// Assumes : Bits of a word change far apart or are read while stable
// Notes   : First stage feeds only the second
module sfr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff <= '1;
         q_out   <= '1;
      end else begin
         meta_ff <= d_in;
         q_out   <= meta_ff;
      end
   end
endmodule

//--- rtl/sfr_device.sv
// Purpose : Flash front end: status register, write latch, array reads
// Assumes : Host stops the serial clock while chip select is high
// Notes   : Link logic runs on sck; status keeping runs on ref_clk_in
// Function
// - Locked and protect pin low: ignore status write
// - Protect pin high: status writable whatever the lock bit
// - Status read accepted at any time
// - Status bits out MSB first from 8th fall
// - Status byte repeats while clocks continue
// - Output undriven while chip select high
// - Status write is command plus byte, on deselect
// - Busy, latch and suspend bits not writable
// - Protect bits kept persistently, self-timed update
// - Busy bit set during status update
// - Host raises protect pin, enables writing first
// - Writes refused while write latch clear
// - Write enable alone sets latch on deselect
// - Write disable alone clears latch on deselect
// - Low-power read data from 32nd fall
// - Sample on rising edge, drive on falling
// - Address increments per byte and wraps
// - Fast read: dummy byte, data from 40th fall
// - Deselect ends read and releases output
// - Status bit positions busy to suspend
// - Write latch cleared at reset and completion
module sfr_device
   import sfr_pkg::*;
#(
   parameter int SR_WRITE_CYC = SR_WRITE_CYCLES
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   sfr_link_if.device      link,
   output logic      [7:0] status_out,
   output logic            sr_write_done_out
);
   localparam int TMR_W = $clog2(SR_WRITE_CYC + 1);
   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(SR_WRITE_CYC - 1);

   // ****************************************
   // Link domain: frame tracking
   // ****************************************
   logic              frame_rst;
   logic              in_frame_ff;
   logic [5:0]        cnt_ff;
   logic [5:0]        nxt_cnt;
   logic [2:0]        bitpos_ff;
   logic [7:0]        sh_ff;
   logic [7:0]        cmd_ff;
   logic [7:0]        wdata_ff;
   logic [23:0]       addr_ff;
   logic [7:0]        status_sck;
   logic [5:0]        start_cnt;
   logic              is_read;
   logic              data_phase;
   logic [7:0]        out_byte;
   logic              so_ff;
   logic              oe_ff;

   assign frame_rst = rst_in | link.cs_n;

   always_ff @(posedge link.sck or posedge frame_rst) begin
      if (frame_rst) begin
         in_frame_ff <= 1'b0;
      end else begin
         in_frame_ff <= 1'b1;
      end
   end

   always_comb begin
      if (!in_frame_ff) begin
         nxt_cnt = 6'h01;
      end else if (cnt_ff == CNT_MAX) begin
         nxt_cnt = CNT_MAX;
      end else begin
         nxt_cnt = cnt_ff + 6'h01;
      end
   end

   // Count survives deselect so the status side can judge frame length
   always_ff @(posedge link.sck or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff    <= '0;
         bitpos_ff <= '0;
      end else begin
         cnt_ff    <= nxt_cnt;
         bitpos_ff <= in_frame_ff ? bitpos_ff + 3'h1 : 3'h1;
      end
   end

   always_ff @(posedge link.sck or posedge rst_in) begin
      if (rst_in) begin
         sh_ff <= '0;
      end else begin
         sh_ff <= {sh_ff[6:0], link.si};
      end
   end

   always_ff @(posedge link.sck or posedge rst_in) begin
      if (rst_in) begin
         cmd_ff <= '0;
      end else if (in_frame_ff && cnt_ff == CNT_CMD_END) begin
         cmd_ff <= {sh_ff[6:0], link.si};
      end
   end

   always_ff @(posedge link.sck or posedge rst_in) begin
      if (rst_in) begin
         wdata_ff <= '0;
      end else if (in_frame_ff && cnt_ff == CNT_DATA_END) begin
         wdata_ff <= {sh_ff[6:0], link.si};
      end
   end

   always_comb begin
      start_cnt = CNT_MAX;
      is_read   = 1'b0;
      unique case (cmd_ff)
         CMD_STATUS_READ: start_cnt = START_STATUS;
         CMD_LOW_PWR_READ: begin
            start_cnt = START_LP_READ;
            is_read   = 1'b1;
         end
         CMD_FAST_READ: begin
            start_cnt = START_FAST;
            is_read   = 1'b1;
         end
         default: start_cnt = CNT_MAX;
      endcase
   end

   assign data_phase = in_frame_ff && (cnt_ff >= CNT_ADDR_LO) && (cnt_ff >= start_cnt)
                       && (start_cnt != CNT_MAX);

   always_ff @(posedge link.sck or posedge rst_in) begin
      if (rst_in) begin
         addr_ff <= '0;
      end else if (in_frame_ff && cnt_ff >= CNT_ADDR_LO && cnt_ff <= CNT_ADDR_HI) begin
         addr_ff <= {addr_ff[22:0], link.si};
      end else if (data_phase && is_read && bitpos_ff == BIT_LAST) begin
         addr_ff[ADDR_W-1:0] <= addr_ff[ADDR_W-1:0] + ADDR_W'(1);
      end
   end

   sfr_sync #(
      .WIDTH (8)
   ) u_status_sync (
      .clk_in (link.sck),
      .rst_in (rst_in),
      .d_in   (status_out),
      .q_out  (status_sck)
   );

   assign out_byte = is_read ? sfr_fill_byte(addr_ff[ADDR_W-1:0]) : status_sck;

   always_ff @(negedge link.sck or posedge frame_rst) begin
      if (frame_rst) begin
         so_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (data_phase) begin
         so_ff <= out_byte[~bitpos_ff];
         oe_ff <= 1'b1;
      end
   end

   assign link.so    = so_ff;
   assign link.so_oe = oe_ff & ~link.cs_n;

   // ****************************************
   // Reference domain: status keeping
   // ****************************************
   logic              cs_s;
   logic              wp_s;
   logic              cs_del_ff;
   logic              frame_end;
   logic              unprotected;
   logic              start_wr;
   logic              finish_wr;
   logic              wel_ff;
   logic              busy_ff;
   logic [7:0]        nv_ff;
   logic [7:0]        pend_ff;
   logic [TMR_W-1:0]  tmr_ff;

   sfr_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_in (ref_clk_in),
      .rst_in (rst_in),
      .d_in   ({link.cs_n, link.wp_n}),
      .q_out  ({cs_s, wp_s})
   );

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_del_ff <= 1'b1;
      end else begin
         cs_del_ff <= cs_s;
      end
   end

   // Frame words are stable here: the clock is stopped once deselected
   assign frame_end   = cs_s & ~cs_del_ff;
   assign unprotected = wp_s | ~nv_ff[SR_LOCK];
   assign start_wr    = frame_end & ~busy_ff & (cmd_ff == CMD_STATUS_WRITE)
                        & (cnt_ff == LEN_STATUS_WR) & wel_ff & unprotected;
   assign finish_wr   = busy_ff & (tmr_ff == '0);

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wel_ff <= 1'b0;
      end else if (finish_wr) begin
         wel_ff <= 1'b0;
      end else if (frame_end && !busy_ff && cnt_ff == LEN_CMD_ONLY) begin
         if (cmd_ff == CMD_WRITE_EN) begin
            wel_ff <= 1'b1;
         end else if (cmd_ff == CMD_WRITE_DIS) begin
            wel_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_ff <= 1'b0;
         tmr_ff  <= '0;
      end else if (start_wr) begin
         busy_ff <= 1'b1;
         tmr_ff  <= TMR_LOAD;
      end else if (busy_ff) begin
         busy_ff <= ~finish_wr;
         tmr_ff  <= finish_wr ? tmr_ff : tmr_ff - TMR_W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_ff <= SR_RESET;
         nv_ff   <= SR_RESET;
      end else if (start_wr) begin
         pend_ff <= wdata_ff & SR_NV_MASK;
      end else if (finish_wr) begin
         nv_ff   <= pend_ff;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_out        <= SR_RESET;
         sr_write_done_out <= 1'b0;
      end else begin
         status_out                <= nv_ff;
         status_out[SR_WEL]        <= wel_ff;
         status_out[SR_BUSY]       <= busy_ff;
         sr_write_done_out         <= finish_wr;
      end
   end
endmodule

//--- rtl/sfr_host.sv
// Purpose : Host controller driving the serial flash link in mode 0
// Assumes : Serial clock is ref_clk_in divided by twice HALF_SCK
// Notes   : A status write is preceded by its own write enable frame
module sfr_host
   import sfr_pkg::*;
#(
   parameter int HALF_SCK = HOST_HALF_SCK,
   parameter int GAP_CYC  = HOST_GAP_CYCLES,
   parameter int RD_W     = 16
) (
   input  wire logic            ref_clk_in,
   input  wire logic            rst_in,
   sfr_link_if.host             link,
   input  wire logic            req_valid_in,
   output logic                 req_ready_out,
   input  wire logic [7:0]      req_cmd_in,
   input  wire logic [23:0]     req_addr_in,
   input  wire logic [7:0]      req_wdata_in,
   input  wire logic [RD_W-1:0] req_rd_bytes_in,
   input  wire logic            wp_level_in,
   output logic      [7:0]      rd_data_out,
   output logic                 rd_valid_out,
   output logic                 done_out
);
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LOW  = 2'b01,
      HS_HIGH = 2'b11,
      HS_GAP  = 2'b10
   } sfr_hstate_t;

   localparam int BITS_W = RD_W + 4;

   sfr_hstate_t       state_ff;
   logic [7:0]        div_ff;
   logic [39:0]       tx_ff;
   logic [5:0]        tx_left_ff;
   logic [BITS_W-1:0] bits_left_ff;
   logic [7:0]        rx_ff;
   logic [2:0]        rx_cnt_ff;
   logic              status_write_cmd_pend_ff;
   logic              status_write_cmd_seq_ff;
   logic [7:0]        wdata_ff;
   logic              so_s;
   logic              div_end;
   logic              rx_bit;
   logic              is_rd;
   logic [5:0]        ld_tx_bits;

   sfr_sync #(
      .WIDTH (1)
   ) u_so_sync (
      .clk_in (ref_clk_in),
      .rst_in (rst_in),
      .d_in   (link.so_line),
      .q_out  (so_s)
   );

   assign div_end       = (div_ff == 8'(HALF_SCK - 1));
   assign req_ready_out = (state_ff == HS_IDLE);
   assign rx_bit        = (tx_left_ff == '0);
   assign is_rd = (req_cmd_in == CMD_STATUS_READ) || (req_cmd_in == CMD_LOW_PWR_READ)
                  || (req_cmd_in == CMD_FAST_READ);

   always_comb begin
      unique case (req_cmd_in)
         CMD_LOW_PWR_READ: ld_tx_bits = START_LP_READ;
         CMD_FAST_READ:    ld_tx_bits = START_FAST;
         CMD_STATUS_WRITE: ld_tx_bits = LEN_STATUS_WR;
         default:          ld_tx_bits = LEN_CMD_ONLY;
      endcase
   end

   // ****************************************
   // Frame engine
   // ****************************************
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff     <= HS_IDLE;
         div_ff       <= '0;
         tx_ff        <= '0;
         tx_left_ff   <= '0;
         bits_left_ff <= '0;
         status_write_cmd_pend_ff <= 1'b0;
         wdata_ff     <= '0;
         link.cs_n    <= 1'b1;
         link.sck     <= 1'b0;
      end else begin
         div_ff <= div_end ? 8'h00 : div_ff + 8'h01;
         unique case (state_ff)
            HS_IDLE: begin
               div_ff <= '0;
               if (req_valid_in) begin
                  state_ff  <= HS_LOW;
                  link.cs_n <= 1'b0;
                  wdata_ff  <= req_wdata_in;
                  if (req_cmd_in == CMD_STATUS_WRITE) begin
                     status_write_cmd_pend_ff <= 1'b1;
                     tx_ff        <= {CMD_WRITE_EN, 32'h0};
                     tx_left_ff   <= LEN_CMD_ONLY;
                     bits_left_ff <= BITS_W'(LEN_CMD_ONLY);
                  end else begin
                     tx_ff        <= {req_cmd_in, req_addr_in, 8'h00};
                     tx_left_ff   <= ld_tx_bits;
                     bits_left_ff <= BITS_W'(ld_tx_bits)
                                     + (is_rd ? BITS_W'({req_rd_bytes_in, 3'h0}) : '0);
                  end
               end
            end
            HS_LOW: begin
               if (div_end) begin
                  link.sck <= 1'b1;
                  state_ff <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               if (div_end) begin
                  link.sck     <= 1'b0;
                  tx_ff        <= {tx_ff[38:0], 1'b0};
                  tx_left_ff   <= rx_bit ? tx_left_ff : tx_left_ff - 6'h01;
                  bits_left_ff <= bits_left_ff - BITS_W'(1);
                  if (bits_left_ff == BITS_W'(1)) begin
                     link.cs_n <= 1'b1;
                     state_ff  <= HS_GAP;
                  end else begin
                     state_ff  <= HS_LOW;
                  end
               end
            end
            HS_GAP: begin
               // Gap counts freely: the divider wrap would never reach the gap length
               div_ff <= div_ff + 8'h01;
               if (div_ff == 8'(GAP_CYC - 1)) begin
                  div_ff <= '0;
                  if (status_write_cmd_pend_ff) begin
                     status_write_cmd_pend_ff <= 1'b0;
                     link.cs_n    <= 1'b0;
                     tx_ff        <= {CMD_STATUS_WRITE, wdata_ff, 24'h0};
                     tx_left_ff   <= LEN_STATUS_WR;
                     bits_left_ff <= BITS_W'(LEN_STATUS_WR);
                     state_ff     <= HS_LOW;
                  end else begin
                     state_ff <= HS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   assign link.si = tx_ff[39];

   // host samples late in high phase
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_ff        <= '0;
         rx_cnt_ff    <= '0;
         rd_data_out  <= '0;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= 1'b0;
         if (state_ff == HS_IDLE) begin
            rx_cnt_ff <= '0;
         end else if (state_ff == HS_HIGH && div_end && rx_bit) begin
            rx_ff     <= {rx_ff[6:0], so_s};
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == BIT_LAST) begin
               rd_data_out  <= {rx_ff[6:0], so_s};
               rd_valid_out <= 1'b1;
            end
         end
      end
   end

   // protect pin high for status write
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_write_cmd_seq_ff <= 1'b0;
         link.wp_n   <= 1'b1;
         done_out    <= 1'b0;
      end else begin
         done_out  <= (state_ff == HS_GAP) && (div_ff == 8'(GAP_CYC - 1)) && !status_write_cmd_pend_ff;
         link.wp_n <= wp_level_in | status_write_cmd_seq_ff;
         if (state_ff == HS_IDLE && req_valid_in) begin
            status_write_cmd_seq_ff <= (req_cmd_in == CMD_STATUS_WRITE);
         end else if (done_out) begin
            status_write_cmd_seq_ff <= 1'b0;
         end
      end
   end
endmodule

//--- verification/sfr_monitor.sv
// Purpose: Assertions on the link between host and flash front end
// Assumes: Mode 0 link, serial clock stopped between frames
// Notes  : Rise counter is cleared while deselected and saturates
module sfr_monitor (
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic so,
   input  wire logic so_oe,
   input  wire logic wp_n,
   input  wire logic so_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Frame tracking
   // ****************
   logic [6:0] rise_cnt_ff;
   logic [7:0] cmd_ff;
   logic [6:0] start;

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) rise_cnt_ff <= 7'h00;
      else if (rise_cnt_ff != 7'h7F) rise_cnt_ff <= rise_cnt_ff + 7'h01;
   end

   // Only the first byte of a frame is a command
   always_ff @(posedge sck) begin
      if (rise_cnt_ff < 7'h08) cmd_ff <= {cmd_ff[6:0], si};
   end

   always_comb begin
      case (cmd_ff)
         8'h05:   start = 7'h08;
         8'h03:   start = 7'h20;
         8'h0B:   start = 7'h28;
         default: start = 7'h7F;
      endcase
   end
   // ****************
   // Checks
   // ****************
   a_release_when_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cs_n |-> !so_oe && so_line) else $error("output driven while deselected");
   a_status_start: assert property (@(posedge sck) disable iff (rst_in || cs_n)
      (cmd_ff == 8'h05 && rise_cnt_ff == 7'h08) |-> so_oe) else $error("status late");
   a_no_early_drive: assert property (@(posedge sck) disable iff (rst_in || cs_n)
      so_oe |-> rise_cnt_ff >= start) else $error("output driven too early");
   a_status_repeat: assert property (@(negedge sck) disable iff (rst_in || cs_n)
      (cmd_ff == 8'h05 && rise_cnt_ff >= 7'h11) |-> so == $past(so, 8))
      else $error("status byte not repeated");
   a_drive_on_fall: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!cs_n && $changed(so)) |-> $fell(sck)) else $error("output moved off a fall");
   a_host_si_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!cs_n && $changed(si)) |-> !sck) else $error("input moved with clock high");
   a_idle_clock_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cs_n |-> !sck) else $error("clock runs while deselected");
   a_whole_bytes: assert property (@(posedge cs_n) disable iff (rst_in)
      rise_cnt_ff[2:0] == 3'h0) else $error("frame not whole bytes");
   a_protect_pin_up: assert property (@(posedge sck) disable iff (rst_in || cs_n)
      (cmd_ff == 8'h01 && rise_cnt_ff == 7'h08) |-> wp_n) else $error("protect pin low");
   a_deselect_gap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(cs_n) |-> cs_n [*4]) else $error("deselect gap too short");

   c_status_read: cover property (@(posedge sck) cmd_ff == 8'h05 && rise_cnt_ff == 7'h10);
   c_fast_read: cover property (@(posedge sck) cmd_ff == 8'h0B && rise_cnt_ff == 7'h30);
   c_status_write: cover property (@(posedge cs_n) cmd_ff == 8'h01 && rise_cnt_ff == 7'h10);
endmodule

//--- verification/sfr_bench.sv
// Purpose: Self-checking bench for host and flash front end
// Assumes: Second link is bit-banged by the bench to break host habits
// Notes  : Short write time on the second device keeps the run brief
module serial_flash_status_and_read_front_end_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WR_CYC = 300;
   logic        clk, rst, valid, ready, rvalid, done, wdone, wp;
   logic [7:0]  cmd, wdata, rdata, st_a, st_b;
   logic [23:0] addr;
   logic [15:0] nrd;
   logic [7:0]  got[$];
   int          failures, n_compared;

   sfr_link_if lk();
   sfr_link_if lk2();
   sfr_host i_sfr_host (.ref_clk_in(clk), .rst_in(rst), .link(lk), .req_valid_in(valid),
      .req_ready_out(ready), .req_cmd_in(cmd), .req_addr_in(addr), .req_wdata_in(wdata),
      .req_rd_bytes_in(nrd), .wp_level_in(wp), .rd_data_out(rdata),
      .rd_valid_out(rvalid), .done_out(done));
   sfr_device #(.SR_WRITE_CYC(WR_CYC)) i_sfr_device (.ref_clk_in(clk), .rst_in(rst),
      .link(lk), .status_out(st_a), .sr_write_done_out(wdone));
   // Second device faces the bench so refused writes can be provoked
   sfr_device #(.SR_WRITE_CYC(5)) i_sfr_device_b (.ref_clk_in(clk), .rst_in(rst),
      .link(lk2), .status_out(st_b), .sr_write_done_out());
   sfr_monitor i_sfr_monitor (.ref_clk_in(clk), .rst_in(rst), .cs_n(lk.cs_n),
      .sck(lk.sck), .si(lk.si), .so(lk.so), .so_oe(lk.so_oe), .wp_n(lk.wp_n),
      .so_line(lk.so_line));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ****************
   // Helpers
   // ****************
   function automatic logic [7:0] pat(input logic [20:0] a);
      return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
   endfunction

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic run(input logic [7:0] c, input logic [23:0] a, input logic [7:0] w,
                      input logic [15:0] n);
      int k;
      got.delete();
      @(negedge clk);
      cmd = c;
      addr = a;
      wdata = w;
      nrd = n;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20000) begin
         @(negedge clk);
         if (rvalid === 1'b1) got.push_back(rdata);
         k++;
      end
      if (k >= 20000) begin
         failures++;
         $display("FAIL %0t timeout waiting for done", $time);
         finish_test();
      end
   endtask

   // Frame on the second link, MSB first, clock stands still outside it
   task automatic frame2(input logic [15:0] v, input int n);
      @(negedge clk);
      lk2.cs_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         lk2.si = v[i];
         #3 lk2.sck = 1'b1;
         #3 lk2.sck = 1'b0;
      end
      #3 lk2.cs_n = 1'b1;
      lk2.si = ~lk2.si;
      idle(20);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      chk(st_a, 8'h00);
      chk({7'h00, lk.so_line}, 8'h01);
      run(8'h05, 24'h000000, 8'h00, 16'h0002);
      chk({7'h00, ready}, 8'h01);
      chk(got[0], 8'h00);
      chk(got[1], 8'h00);
   endtask

   task automatic t_latch();
      run(8'h06, 24'h000000, 8'h00, 16'h0000);
      idle(4);
      chk(st_a, 8'h02);
      run(8'h05, 24'h000000, 8'h00, 16'h0001);
      chk(got[0], 8'h02);
      run(8'h04, 24'h000000, 8'h00, 16'h0000);
      idle(4);
      chk(st_a, 8'h00);
   endtask

   task automatic t_status_write();
      int k;
      // Host must lift the protect pin itself for the write
      wp = 1'b0;
      run(8'h01, 24'h000000, 8'hFF, 16'h0000);
      run(8'h05, 24'h000000, 8'h00, 16'h0002);
      chk(got[0], 8'h03);
      chk(got[1], 8'h03);
      k = 0;
      while (wdone !== 1'b1 && k < WR_CYC + 20) begin
         @(negedge clk);
         k++;
      end
      chk({7'h00, wdone}, 8'h01);
      idle(4);
      chk(st_a, 8'hBC);
      wp = 1'b1;
   endtask

   task automatic t_reads();
      logic [20:0] a;
      run(8'h03, 24'h1FFFFE, 8'h00, 16'h0003);
      a = 21'h1FFFFE;
      for (int i = 0; i < 3; i++) begin
         chk(got[i], pat(a));
         a = a + 21'h000001;
      end
      run(8'h0B, 24'hE01234, 8'h00, 16'h0002);
      chk(got[0], pat(21'h001234));
      chk(got[1], pat(21'h001235));
      chk({7'h00, lk.so_line}, 8'h01);
   endtask

   task automatic t_protect();
      frame2(16'h01FF, 16);
      chk(st_b, 8'h00);
      frame2(16'h0600, 8);
      frame2(16'h019C, 16);
      chk(st_b, 8'h9C);
      lk2.wp_n = 1'b0;
      frame2(16'h0600, 8);
      frame2(16'h0100, 16);
      chk(st_b, 8'h9E);
      lk2.wp_n = 1'b1;
      frame2(16'h0100, 16);
      chk(st_b, 8'h00);
   endtask

   initial begin
      rst = 1'b1;
      valid = 1'b0;
      wp = 1'b1;
      cmd = 8'h00;
      addr = 24'h000000;
      wdata = 8'h00;
      nrd = 16'h0000;
      failures = 0;
      n_compared = 0;
      lk2.cs_n = 1'b1;
      lk2.sck = 1'b0;
      lk2.si = 1'b0;
      lk2.wp_n = 1'b1;
      idle(4);
      rst = 1'b0;
      idle(4);
      t_reset();
      t_latch();
      t_status_write();
      t_reads();
      t_protect();
      finish_test();
   end
endmodule
